/* design/umcps_top.sv */
// Modem-control pins for two serial channels and power-on strap latching
// Summary of operation
// - Clear-to-send level readable at bit 4 of each channel's handshake status.
// - Request-to-send pin low when controller ready to send, otherwise high, unless channel A's pin is lent to GPIO.
// - Terminal-ready pin low when controller ready to communicate, otherwise high, unless channel A's pin is lent to GPIO.
// - Channel A request-to-send pulled low at reset; level sets port-address bit 6.
// - Channel A terminal-ready pulled low at reset; level sets ROM-enable bit 1.
`default_nettype none
module umcps_top
    import umcps_pkg::*;
#(
    parameter int SETTLE_CYC = STRAP_SETTLE_CYC
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic clear_to_send_in_a,
    input wire logic clear_to_send_in_b,
    input wire logic set_ready_in_a,
    input wire logic set_ready_in_b,
    input wire logic carrier_detect_in_a,
    input wire logic carrier_detect_in_b,
    input wire logic ring_indicate_in_a,
    input wire logic ring_indicate_in_b,
    input wire logic ready_to_send_a,
    input wire logic ready_to_send_b,
    input wire logic ready_to_comm_a,
    input wire logic ready_to_comm_b,
    input wire logic gpio_sel_rts_a,
    input wire logic gpio_sel_dtr_a,
    input wire logic gpio_out_rts_a,
    input wire logic gpio_out_dtr_a,
    input wire logic request_send_pin_in_a,
    input wire logic terminal_ready_pin_in_a,
    output logic request_send_out_a,
    output logic request_send_oe_a,
    output logic request_send_pd_a,
    output logic request_send_out_b,
    output logic terminal_ready_out_a,
    output logic terminal_ready_oe_a,
    output logic terminal_ready_pd_a,
    output logic terminal_ready_out_b,
    output logic [HS_STATUS_W-1:0] hs_status_a,
    output logic [HS_STATUS_W-1:0] hs_status_b,
    output logic [CFG26_W-1:0] global_config_reg_26,
    output logic [CFG24_W-1:0] global_config_reg_24,
    output logic [7:0] cfg_port_addr,
    output logic straps_done
);
    logic [9:0] pins_raw;
    logic [9:0] pins_s;
    umcps_state_type state_r;
    umcps_state_type state_nxt;
    logic [STRAP_CNT_W-1:0] cnt_r;
    logic [STRAP_CNT_W-1:0] cnt_nxt;
    logic strap_sample;
    logic strap_rts_s;
    logic strap_dtr_s;
    logic pins_owned;

    // Active-low pin in, active-high status bits out
    function automatic logic [HS_STATUS_W-1:0] hs_pack(input logic cts_n, input logic dsr_n,
                                                       input logic ri_n, input logic dcd_n);
        logic [HS_STATUS_W-1:0] v;
        v = '0;
        v[HS_CTS_BIT] = ~cts_n;
        v[HS_DSR_BIT] = ~dsr_n;
        v[HS_RI_BIT] = ~ri_n;
        v[HS_DCD_BIT] = ~dcd_n;
        return v;
    endfunction : hs_pack

    // Active-low pin: a ready controller pulls it low unless the pin is lent to GPIO
    function automatic logic pin_level(input logic gpio_sel, input logic gpio_out,
                                       input logic ready);
        logic lvl;
        lvl = ~ready;
        if (gpio_sel) begin
            lvl = gpio_out;
        end
        return lvl;
    endfunction : pin_level

    assign pins_raw = {terminal_ready_pin_in_a, request_send_pin_in_a,
                       ring_indicate_in_b, ring_indicate_in_a,
                       carrier_detect_in_b, carrier_detect_in_a,
                       set_ready_in_b, set_ready_in_a,
                       clear_to_send_in_b, clear_to_send_in_a};

    // Strap pins reset low to match the internal pull-down
    umcps_sync #(.W(10), .INIT(10'h0ff)) u_sync (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .d(pins_raw),
        .q(pins_s)
    );

    // Sample once the synchronised strap level has settled
    assign strap_sample = (state_r == UMCPS_ST_SAMPLE) &&
                          (cnt_r == STRAP_CNT_W'(SETTLE_CYC - 1));
    assign strap_rts_s = pins_s[8];
    assign strap_dtr_s = pins_s[9];
    assign pins_owned = strap_sample || straps_done;

    // Strap window sequencing
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        case (state_r)
            UMCPS_ST_RESET: begin
                state_nxt = UMCPS_ST_SAMPLE;
                cnt_nxt = '0;
            end
            UMCPS_ST_SAMPLE: begin
                if (strap_sample) begin
                    state_nxt = UMCPS_ST_RUN;
                end else begin
                    cnt_nxt = cnt_r + STRAP_CNT_W'(1);
                end
            end
            UMCPS_ST_RUN: begin
                state_nxt = UMCPS_ST_RUN;
            end
            default: begin
                state_nxt = UMCPS_ST_RESET;
                cnt_nxt = '0;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_r <= UMCPS_ST_RESET;
        end else if (ce) begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            cnt_r <= '0;
        end else if (ce) begin
            cnt_r <= cnt_nxt;
        end
    end

    // Pull-downs hold only through the strap window
    always_ff @(posedge mclk) begin
        if (rst) begin
            request_send_pd_a <= 1'b1;
            terminal_ready_pd_a <= 1'b1;
            straps_done <= 1'b0;
        end else if (ce && strap_sample) begin
            request_send_pd_a <= 1'b0;
            terminal_ready_pd_a <= 1'b0;
            straps_done <= 1'b1;
        end
    end

    // Taken once per reset; later pad activity never reaches these bits
    always_ff @(posedge mclk) begin
        if (rst) begin
            global_config_reg_26 <= CFG26_RST;
            cfg_port_addr <= CFG_PORT_ADDR_STRAP_LO;
        end else if (ce && strap_sample) begin
            global_config_reg_26[CFG26_PORT_ADDR_BIT] <= strap_rts_s;
            cfg_port_addr <= strap_rts_s ? CFG_PORT_ADDR_STRAP_HI
                                         : CFG_PORT_ADDR_STRAP_LO;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            global_config_reg_24 <= CFG24_RST;
        end else if (ce && strap_sample) begin
            global_config_reg_24[CFG24_ROM_EN_BIT] <= strap_dtr_s;
        end
    end

    // Channel A pins stay undriven while the straps are read
    always_ff @(posedge mclk) begin
        if (rst) begin
            request_send_oe_a <= 1'b0;
            terminal_ready_oe_a <= 1'b0;
        end else if (ce) begin
            request_send_oe_a <= pins_owned;
            terminal_ready_oe_a <= pins_owned;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            request_send_out_a <= 1'b1;
            terminal_ready_out_a <= 1'b1;
        end else if (ce) begin
            request_send_out_a <= pin_level(gpio_sel_rts_a, gpio_out_rts_a,
                                            ready_to_send_a);
            terminal_ready_out_a <= pin_level(gpio_sel_dtr_a, gpio_out_dtr_a,
                                              ready_to_comm_a);
        end
    end

    // Channel B has no GPIO option
    always_ff @(posedge mclk) begin
        if (rst) begin
            request_send_out_b <= 1'b1;
            terminal_ready_out_b <= 1'b1;
        end else if (ce) begin
            request_send_out_b <= pin_level(1'b0, 1'b0, ready_to_send_b);
            terminal_ready_out_b <= pin_level(1'b0, 1'b0, ready_to_comm_b);
        end
    end

    // Handshake status from synchronised modem inputs
    always_ff @(posedge mclk) begin
        if (rst) begin
            hs_status_a <= '0;
            hs_status_b <= '0;
        end else if (ce) begin
            hs_status_a <= hs_pack(pins_s[0], pins_s[2], pins_s[6], pins_s[4]);
            hs_status_b <= hs_pack(pins_s[1], pins_s[3], pins_s[7], pins_s[5]);
        end
    end
endmodule : umcps_top
`default_nettype wire

/* shared/umcps_pkg.sv */
// Constants for modem-control pins and power-on straps
`default_nettype none
package umcps_pkg;
    localparam int NUM_CHAN = 2;
    localparam int CH_A = 0;
    localparam int CH_B = 1;
    localparam int HS_STATUS_W = 8;
    localparam int HS_CTS_BIT = 4;
    localparam int HS_DSR_BIT = 5;
    localparam int HS_RI_BIT = 6;
    localparam int HS_DCD_BIT = 7;
    localparam int CFG26_W = 8;
    localparam int CFG26_PORT_ADDR_BIT = 6;
    localparam int CFG24_W = 8;
    localparam int CFG24_ROM_EN_BIT = 1;
    localparam logic [7:0] CFG_PORT_ADDR_STRAP_HI = 8'h4e;
    localparam logic [7:0] CFG_PORT_ADDR_STRAP_LO = 8'h2e;
    localparam logic [7:0] CFG26_RST = 8'h00;
    localparam logic [7:0] CFG24_RST = 8'h00;
    // Strap sampling window after reset release, in cycles
    localparam int STRAP_SETTLE_CYC = 4;
    localparam int STRAP_CNT_W = 3;
    typedef enum logic [1:0] {
        UMCPS_ST_RESET = 2'b00,
        UMCPS_ST_SAMPLE = 2'b01,
        UMCPS_ST_RUN = 2'b11
    } umcps_state_type;
endpackage : umcps_pkg
`default_nettype wire

/* design/umcps_sync.sv */
// Two-flop synchroniser for a vector of pin inputs
`default_nettype none
module umcps_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '1
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge mclk) begin
        if (rst) begin
            meta_r <= INIT;
            q <= INIT;
        end else if (ce) begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule : umcps_sync
`default_nettype wire

/* testbench/umcps_assertions.sv */
// Checker for modem-control pins and strap latching
`default_nettype none
module umcps_assertions
    import umcps_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic clear_to_send_in_a,
    input wire logic clear_to_send_in_b,
    input wire logic ready_to_send_b,
    input wire logic ready_to_comm_b,
    input wire logic request_send_pin_in_a,
    input wire logic terminal_ready_pin_in_a,
    input wire logic request_send_out_b,
    input wire logic terminal_ready_out_b,
    input wire logic request_send_oe_a,
    input wire logic request_send_pd_a,
    input wire logic terminal_ready_pd_a,
    input wire logic [HS_STATUS_W-1:0] hs_status_a,
    input wire logic [HS_STATUS_W-1:0] hs_status_b,
    input wire logic [CFG26_W-1:0] global_config_reg_26,
    input wire logic [CFG24_W-1:0] global_config_reg_24,
    input wire logic straps_done
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    sequence s_capture;
        $rose(straps_done);
    endsequence
    a_cts_level: assert property (straps_done |->
        hs_status_a[HS_CTS_BIT] == !$past(clear_to_send_in_a, 3)
        && hs_status_b[HS_CTS_BIT] == !$past(clear_to_send_in_b, 3)) else $error("cts status");
    a_rts_follow: assert property (straps_done |->
        request_send_out_b == !$past(ready_to_send_b)) else $error("rts level");
    a_dtr_follow: assert property (straps_done |->
        terminal_ready_out_b == !$past(ready_to_comm_b)) else $error("dtr level");
    a_strap_pull: assert property (!straps_done |->
        request_send_pd_a && terminal_ready_pd_a && !request_send_oe_a) else $error("pull");
    a_strap_value: assert property (s_capture |->
        global_config_reg_26[CFG26_PORT_ADDR_BIT] == $past(request_send_pin_in_a, 3)
        && global_config_reg_24[CFG24_ROM_EN_BIT] == $past(terminal_ready_pin_in_a, 3))
        else $error("strap value");
    a_straps_kept: assert property (straps_done && $past(straps_done) |->
        $stable(global_config_reg_26) && $stable(global_config_reg_24)) else $error("kept");
    a_pins_freed: assert property ($fell(rst) |-> ##[3:8] s_capture ##0
        !request_send_pd_a && !terminal_ready_pd_a && request_send_oe_a) else $error("free");
endmodule : umcps_assertions
bind umcps_top umcps_assertions chk (.*);
`default_nettype wire

/* testbench/umcps_modem_model.sv */
// Modem side model: status pins and channel A strap pads
`default_nettype none
module umcps_modem_model (
    input wire logic [7:0] asrt,
    input wire logic [1:0] up,
    input wire logic [1:0] out,
    input wire logic [1:0] oe,
    input wire logic [1:0] pd,
    output logic [7:0] pins,
    output logic [1:0] pad
);
    timeunit 1ns;
    timeprecision 1ns;
    assign pins = ~asrt;
    // Strong pull-up beats weak pull-down; a floating pad shows the inverse of out
    assign pad = (oe & out) | (~oe & up) | (~oe & ~up & ~pd & ~out);
endmodule : umcps_modem_model
`default_nettype wire

/* testbench/tb_top.sv */
// Self-checking bench for modem-control pins and straps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin bad_count++; \
    $display("ERROR %0t mismatch %h %h", $time, a, b); end end
module tb_top
    import umcps_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 0, rst = 1, ce = 1;
    logic [7:0] asrt, pins, hs_status_a, hs_status_b, cfg_port_addr;
    logic [7:0] global_config_reg_26, global_config_reg_24;
    logic [1:0] up, pad;
    logic ready_to_send_a, ready_to_send_b, ready_to_comm_a, ready_to_comm_b;
    logic gpio_sel_rts_a, gpio_sel_dtr_a, gpio_out_rts_a, gpio_out_dtr_a;
    logic request_send_out_a, request_send_oe_a, request_send_pd_a, request_send_out_b;
    logic terminal_ready_out_a, terminal_ready_oe_a, terminal_ready_pd_a, terminal_ready_out_b;
    logic straps_done, request_send_pin_in_a, terminal_ready_pin_in_a;
    logic clear_to_send_in_a, set_ready_in_a, ring_indicate_in_a, carrier_detect_in_a;
    logic clear_to_send_in_b, set_ready_in_b, ring_indicate_in_b, carrier_detect_in_b;
    int bad_count = 0, total_checks = 0, cyc = 0;
    logic [3:0] outs, outs_exp;
    int model_q[$];
    int ent;
    assign {carrier_detect_in_b, ring_indicate_in_b, set_ready_in_b, clear_to_send_in_b,
        carrier_detect_in_a, ring_indicate_in_a, set_ready_in_a, clear_to_send_in_a} = pins;
    assign {terminal_ready_pin_in_a, request_send_pin_in_a} = pad;
    assign outs = {request_send_out_a, request_send_out_b,
        terminal_ready_out_a, terminal_ready_out_b};
    umcps_top uut (.*);
    umcps_modem_model modem (.asrt(asrt), .up(up), .pins(pins), .pad(pad),
        .out({terminal_ready_out_a, request_send_out_a}),
        .oe({terminal_ready_oe_a, request_send_oe_a}),
        .pd({terminal_ready_pd_a, request_send_pd_a}));
    initial forever #25 mclk = ~mclk;
    task automatic end_of_test;
        $display("checks %0d errors %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_of_test
    task automatic do_reset(input logic [1:0] u);
        int n;
        rst = 1;
        up = u;
        repeat (12) @(negedge mclk);
        `CHK({request_send_out_b, request_send_pd_a, straps_done}, 3'b110)
        rst = 0;
        n = 0;
        while (straps_done !== 1'b1 && n < 20) begin
            @(negedge mclk);
            n++;
        end
        `CHK(global_config_reg_26, {1'b0, u[0], 6'h00})
        `CHK(cfg_port_addr, u[0] ? 8'h4e : 8'h2e)
        `CHK(global_config_reg_24, {6'h00, u[1], 1'b0})
        `CHK({request_send_pd_a, terminal_ready_pd_a, request_send_oe_a}, 3'b001)
    endtask : do_reset
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            end_of_test();
        end
    end
    // Reference model: one entry per edge; status shows the modem status pins two edges late
    always @(posedge mclk) begin
        if (rst) begin
            model_q.delete();
        end else begin
            model_q.push_back({20'h0, (gpio_sel_rts_a ? gpio_out_rts_a : !ready_to_send_a),
                !ready_to_send_b, (gpio_sel_dtr_a ? gpio_out_dtr_a : !ready_to_comm_a),
                !ready_to_comm_b, asrt});
            if (model_q.size() > 3) begin
                void'(model_q.pop_front());
            end
        end
    end
    always @(negedge mclk) begin
        if (!rst && model_q.size() == 3) begin
            ent = model_q[0];
            `CHK({hs_status_b, hs_status_a}, {ent[7:4], 4'h0, ent[3:0], 4'h0})
            ent = model_q[2];
            `CHK(outs[3:2], ent[11:10])
            `CHK(outs[1:0], ent[9:8])
        end
    end
    initial begin
        {asrt, ready_to_send_a, ready_to_send_b, ready_to_comm_a, ready_to_comm_b,
            gpio_sel_rts_a, gpio_sel_dtr_a, gpio_out_rts_a, gpio_out_dtr_a} = 16'h0000;
        void'($urandom(71));
        for (int s = 0; s < 4; s++) begin
            do_reset(2'(s));
            for (int i = 0; i < 60; i++) begin
                @(negedge mclk);
                {asrt, ready_to_send_a, ready_to_send_b, ready_to_comm_a, ready_to_comm_b,
                    gpio_sel_rts_a, gpio_sel_dtr_a, gpio_out_rts_a, gpio_out_dtr_a} = 16'($urandom);
                repeat (4) @(negedge mclk);
                `CHK({hs_status_b, hs_status_a}, {asrt[7:4], 4'h0, asrt[3:0], 4'h0})
                outs_exp = {gpio_sel_rts_a ? gpio_out_rts_a : !ready_to_send_a, !ready_to_send_b,
                    gpio_sel_dtr_a ? gpio_out_dtr_a : !ready_to_comm_a, !ready_to_comm_b};
                `CHK(outs[3:2], outs_exp[3:2])
                `CHK(outs[1:0], outs_exp[1:0])
            end
        end
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
